/* File: logic/aocg_cfg.svh */
`ifndef AOCG_CFG_SVH
`define AOCG_CFG_SVH

// ==========================================
// Widths
`define AOCG_BIAS_W      15
`define AOCG_SCALE_W     9
`define AOCG_SMP_W       16
`define AOCG_PADDR_W     8
`define AOCG_IDX_W       6
`define AOCG_AXES        3

// ==========================================
// Register indices (byte address is four times the index)
`define AOCG_IDX_X_LO    6'h2A
`define AOCG_IDX_X_HI    6'h2B
`define AOCG_IDX_Y_LO    6'h2C
`define AOCG_IDX_Y_HI    6'h2D
`define AOCG_IDX_Z_LO    6'h2E
`define AOCG_IDX_Z_HI    6'h2F
`define AOCG_IDX_X_SC    6'h30
`define AOCG_IDX_Y_SC    6'h31
`define AOCG_IDX_Z_SC    6'h32
`define AOCG_IDX_CTRL    6'h33
`define AOCG_IDX_STAT    6'h34

// ==========================================
// Field positions
`define AOCG_HI_SCALE_BIT   7
`define AOCG_HI_BIAS_TOP    6
`define AOCG_SCALE_MSB      8
`define AOCG_BIAS_MSB       14
`define AOCG_BIAS_HI_LSB    8
`define AOCG_CTRL_BIAS_EN   0
`define AOCG_CTRL_RELOAD    1
`define AOCG_STAT_LOADING   0
`define AOCG_STAT_MODIFIED  1
`define AOCG_BYTE_LANE      0

// ==========================================
// Reset values
`define AOCG_RST_BIAS_EN    1'h1
`define AOCG_RST_LOAD_PEND  1'h1

`endif

/* File: logic/aocg_pkg.sv */
package aocg_pkg;
`include "aocg_cfg.svh"

   // ==========================================
   // Types
   typedef logic [`AOCG_BIAS_W-1:0]         aocg_bias_type;
   typedef logic [`AOCG_SCALE_W-1:0]        aocg_scale_type;
   typedef logic signed [`AOCG_SMP_W-1:0]   aocg_sample_type;
   typedef logic [`AOCG_IDX_W-1:0]          aocg_index_type;

   typedef enum logic [0:0] {
      AOCG_BUS_IDLE,
      AOCG_BUS_ACCESS
   } aocg_bus_state_type;

endpackage : aocg_pkg

/* File: logic/aocg_axis_cal.sv */
`timescale 1ns/1ps
`include "aocg_cfg.svh"

module aocg_axis_cal
   import aocg_pkg::*;
(
   input  wire logic            i_clk_sys,
   input  wire logic            i_resetn,
   input  wire logic            i_clk_en,
   input  wire logic            i_valid,
   input  wire aocg_sample_type i_sample,
   input  wire aocg_bias_type   i_bias,
   input  wire logic            i_bias_en,
   output aocg_sample_type      o_result
);

   // ==========================================
   // Offset add with saturation
   // One extra bit so the sum never wraps silently
   logic signed [`AOCG_SMP_W:0] sum;
   logic signed [`AOCG_SMP_W:0] bias_ext;
   aocg_sample_type             sat;
   aocg_sample_type             result_q;

   always_comb begin
      bias_ext = i_bias_en ? {{(`AOCG_SMP_W+1-`AOCG_BIAS_W){i_bias[`AOCG_BIAS_MSB]}}, i_bias}
                           : '0;
      sum = {i_sample[`AOCG_SMP_W-1], i_sample} + bias_ext;
      if (sum[`AOCG_SMP_W] != sum[`AOCG_SMP_W-1]) begin
         sat = sum[`AOCG_SMP_W] ? {1'b1, {(`AOCG_SMP_W-1){1'b0}}}
                                : {1'b0, {(`AOCG_SMP_W-1){1'b1}}};
      end else begin
         sat = sum[`AOCG_SMP_W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         result_q <= '0;
      end else if (i_clk_en && i_valid) begin
         result_q <= sat;
      end
   end

   assign o_result = result_q;

endmodule : aocg_axis_cal

/* File: logic/aocg_top.sv */
`timescale 1ns/1ps
`include "aocg_cfg.svh"


module aocg_top
   import aocg_pkg::*;
(
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_resetn,
   input  wire logic                     i_clk_en,
   input  wire logic                     i_psel,
   input  wire logic                     i_penable,
   input  wire logic                     i_pwrite,
   input  wire logic [`AOCG_PADDR_W-1:0] i_paddr,
   input  wire logic [31:0]              i_pwdata,
   input  wire logic [3:0]               i_pstrb,
   output logic [31:0]                   o_prdata,
   output logic                          o_pready,
   output logic                          o_pslverr,
   input  wire logic                     i_smp_valid,
   input  wire aocg_sample_type          i_smp_x,
   input  wire aocg_sample_type          i_smp_y,
   input  wire aocg_sample_type          i_smp_z,
   input  wire aocg_bias_type            i_fact_x_bias,
   input  wire aocg_bias_type            i_fact_y_bias,
   input  wire aocg_bias_type            i_fact_z_bias,
   input  wire aocg_scale_type           i_fact_x_scale,
   input  wire aocg_scale_type           i_fact_y_scale,
   input  wire aocg_scale_type           i_fact_z_scale,
   output logic                          o_ext_valid,
   output aocg_sample_type               o_ext_x,
   output aocg_sample_type               o_ext_y,
   output aocg_sample_type               o_ext_z,
   output aocg_scale_type                o_x_axis_scale,
   output aocg_scale_type                o_y_axis_scale,
   output aocg_scale_type                o_z_axis_scale
);

   // ==========================================
   // Declarations
   aocg_bus_state_type  bus_state_q;
   aocg_bus_state_type  bus_state_d;
   logic                pready_q;
   logic                pslverr_q;
   logic [31:0]         prdata_q;
   logic [7:0]          rd_byte;
   logic                rd_hit;
   aocg_index_type      idx;
   logic                aligned;
   logic                setup;
   logic                access_done;
   logic                wr_fire;
   logic                lane_on;
   logic [7:0]          wbyte;
   logic                bus_idle;
   logic                bus_busy;

   logic                bias_en_q;
   logic                load_pend_q;
   logic                modified_q;
   logic                reload_req;
   logic                cal_wr;

   aocg_bias_type       bias_q  [`AOCG_AXES];
   aocg_scale_type      scale_q [`AOCG_AXES];
   aocg_bias_type       fact_bias  [`AOCG_AXES];
   aocg_scale_type      fact_scale [`AOCG_AXES];
   aocg_sample_type     smp_in [`AOCG_AXES];
   aocg_sample_type     cal_out [`AOCG_AXES];
   logic [`AOCG_AXES-1:0] axis_wr;

   logic                ext_valid_q;
   aocg_scale_type      x_scale_q;
   aocg_scale_type      y_scale_q;
   aocg_scale_type      z_scale_q;

   // ==========================================
   // Bus decode
   assign idx         = i_paddr[`AOCG_PADDR_W-1:2];
   assign aligned     = (i_paddr[1:0] == 2'h0);
   // Phase flags keep a stray penable from closing a transfer
   assign bus_idle    = (bus_state_q == AOCG_BUS_IDLE);
   assign bus_busy    = (bus_state_q == AOCG_BUS_ACCESS);
   assign setup       = bus_idle && i_psel && !i_penable;
   assign access_done = bus_busy && i_psel && i_penable && pready_q;
   assign lane_on     = i_pstrb[`AOCG_BYTE_LANE];
   assign wbyte       = i_pwdata[7:0];
   assign wr_fire     = access_done && i_pwrite && !pslverr_q && lane_on;

   always_comb begin
      bus_state_d = bus_state_q;
      case (bus_state_q)
         AOCG_BUS_IDLE: begin
            if (setup) begin
               bus_state_d = AOCG_BUS_ACCESS;
            end
         end
         AOCG_BUS_ACCESS: begin
            if (access_done) begin
               bus_state_d = AOCG_BUS_IDLE;
            end
         end
         default: begin
            bus_state_d = AOCG_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         bus_state_q <= AOCG_BUS_IDLE;
      end else if (i_clk_en) begin
         bus_state_q <= bus_state_d;
      end
   end

   // ==========================================
   // Read mux
   // Calibration bytes read back so software can merge shared fields
   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      case (idx)
         `AOCG_IDX_X_LO: rd_byte = bias_q[0][7:0];
         `AOCG_IDX_Y_LO: rd_byte = bias_q[1][7:0];
         `AOCG_IDX_Z_LO: rd_byte = bias_q[2][7:0];
         `AOCG_IDX_X_HI: begin
            rd_byte = {scale_q[0][`AOCG_SCALE_MSB],
                       bias_q[0][`AOCG_BIAS_MSB:`AOCG_BIAS_HI_LSB]};
         end
         `AOCG_IDX_Y_HI: begin
            rd_byte = {scale_q[1][`AOCG_SCALE_MSB],
                       bias_q[1][`AOCG_BIAS_MSB:`AOCG_BIAS_HI_LSB]};
         end
         `AOCG_IDX_Z_HI: begin
            rd_byte = {scale_q[2][`AOCG_SCALE_MSB],
                       bias_q[2][`AOCG_BIAS_MSB:`AOCG_BIAS_HI_LSB]};
         end
         `AOCG_IDX_X_SC: rd_byte = scale_q[0][7:0];
         `AOCG_IDX_Y_SC: rd_byte = scale_q[1][7:0];
         `AOCG_IDX_Z_SC: rd_byte = scale_q[2][7:0];
         `AOCG_IDX_CTRL: begin
            rd_byte = 8'h00;
            rd_byte[`AOCG_CTRL_BIAS_EN] = bias_en_q;
         end
         `AOCG_IDX_STAT: begin
            rd_byte = 8'h00;
            rd_byte[`AOCG_STAT_LOADING]  = load_pend_q;
            rd_byte[`AOCG_STAT_MODIFIED] = modified_q;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // ==========================================
   // APB answer: one wait-free access cycle after setup
   // Error settles at setup, so the write gate can trust it
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (i_clk_en) begin
         if (setup) begin
            pready_q  <= 1'b1;
            pslverr_q <= !(rd_hit && aligned);
            prdata_q  <= (rd_hit && aligned && !i_pwrite) ? {24'h00_0000, rd_byte}
                                                           : 32'h0000_0000;
         end else if (access_done) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
         end
      end
   end

   // ==========================================
   // Control register
   // Reload is a one-cycle strobe and always reads back as 0
   assign reload_req = wr_fire && (idx == `AOCG_IDX_CTRL) && wbyte[`AOCG_CTRL_RELOAD];

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         bias_en_q <= `AOCG_RST_BIAS_EN;
      end else if (i_clk_en && wr_fire && idx == `AOCG_IDX_CTRL) begin
         bias_en_q <= wbyte[`AOCG_CTRL_BIAS_EN];
      end
   end

   // Factory values are ports, so reset cannot take them; load after release
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         load_pend_q <= `AOCG_RST_LOAD_PEND;
      end else if (i_clk_en) begin
         if (reload_req) begin
            load_pend_q <= 1'b1;
         end else if (load_pend_q) begin
            load_pend_q <= 1'b0;
         end
      end
   end

   // Set by any calibration write; a write wins over the reload clear
   assign cal_wr = |axis_wr;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         modified_q <= 1'b0;
      end else if (i_clk_en) begin
         if (cal_wr) begin
            modified_q <= 1'b1;
         end else if (load_pend_q) begin
            modified_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // Per-axis calibration storage and offset path
   // A write in the load cycle wins for that whole axis
   assign fact_bias[0]  = i_fact_x_bias;
   assign fact_bias[1]  = i_fact_y_bias;
   assign fact_bias[2]  = i_fact_z_bias;
   assign fact_scale[0] = i_fact_x_scale;
   assign fact_scale[1] = i_fact_y_scale;
   assign fact_scale[2] = i_fact_z_scale;
   assign smp_in[0]     = i_smp_x;
   assign smp_in[1]     = i_smp_y;
   assign smp_in[2]     = i_smp_z;

   generate
      for (genvar g = 0; g < `AOCG_AXES; g++) begin : g_axis
         localparam aocg_index_type LO_IDX = (g == 0) ? `AOCG_IDX_X_LO :
                                             (g == 1) ? `AOCG_IDX_Y_LO : `AOCG_IDX_Z_LO;
         localparam aocg_index_type HI_IDX = (g == 0) ? `AOCG_IDX_X_HI :
                                             (g == 1) ? `AOCG_IDX_Y_HI : `AOCG_IDX_Z_HI;
         localparam aocg_index_type SC_IDX = (g == 0) ? `AOCG_IDX_X_SC :
                                             (g == 1) ? `AOCG_IDX_Y_SC : `AOCG_IDX_Z_SC;
         logic wr_lo;
         logic wr_hi;
         logic wr_sc;

         assign wr_lo = wr_fire && (idx == LO_IDX);
         assign wr_hi = wr_fire && (idx == HI_IDX);
         assign wr_sc = wr_fire && (idx == SC_IDX);
         assign axis_wr[g] = wr_lo || wr_hi || wr_sc;

         // Bias: low byte bits 7..0, high byte bits 14..8
         always_ff @(posedge i_clk_sys or negedge i_resetn) begin
            if (!i_resetn) begin
               bias_q[g] <= '0;
            end else if (i_clk_en) begin
               if (load_pend_q && !axis_wr[g]) begin
                  bias_q[g] <= fact_bias[g];
               end else begin
                  if (wr_lo) begin
                     bias_q[g][7:0] <= wbyte;
                  end
                  if (wr_hi) begin
                     bias_q[g][`AOCG_BIAS_MSB:`AOCG_BIAS_HI_LSB] <=
                        wbyte[`AOCG_HI_BIAS_TOP:0];
                  end
               end
            end
         end

         // Scale: own byte for bits 7..0, high bias byte bit 7 for bit 8
         always_ff @(posedge i_clk_sys or negedge i_resetn) begin
            if (!i_resetn) begin
               scale_q[g] <= '0;
            end else if (i_clk_en) begin
               if (load_pend_q && !axis_wr[g]) begin
                  scale_q[g] <= fact_scale[g];
               end else begin
                  if (wr_sc) begin
                     scale_q[g][7:0] <= wbyte;
                  end
                  if (wr_hi) begin
                     scale_q[g][`AOCG_SCALE_MSB] <= wbyte[`AOCG_HI_SCALE_BIT];
                  end
               end
            end
         end

         // Offset add and result register, one per axis
         aocg_axis_cal u_cal (
            .i_clk_sys (i_clk_sys),
            .i_resetn  (i_resetn),
            .i_clk_en  (i_clk_en),
            .i_valid   (i_smp_valid),
            .i_sample  (smp_in[g]),
            .i_bias    (bias_q[g]),
            .i_bias_en (bias_en_q),
            .o_result  (cal_out[g])
         );
      end
   endgenerate

   // ==========================================
   // Output staging
   // Scale is exported unsigned; its arithmetic lives downstream
   // Results leave straight from the per-axis result flops
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ext_valid_q <= 1'b0;
      end else if (i_clk_en) begin
         ext_valid_q <= i_smp_valid;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         x_scale_q <= '0;
         y_scale_q <= '0;
         z_scale_q <= '0;
      end else if (i_clk_en) begin
         x_scale_q <= scale_q[0];
         y_scale_q <= scale_q[1];
         z_scale_q <= scale_q[2];
      end
   end

   assign o_prdata       = prdata_q;
   assign o_pready       = pready_q;
   assign o_pslverr      = pslverr_q;
   assign o_ext_valid    = ext_valid_q;
   assign o_ext_x        = cal_out[0];
   assign o_ext_y        = cal_out[1];
   assign o_ext_z        = cal_out[2];
   assign o_x_axis_scale = x_scale_q;
   assign o_y_axis_scale = y_scale_q;
   assign o_z_axis_scale = z_scale_q;

endmodule : aocg_top

/* File: sim/aocg_top_properties.sv */
`timescale 1ns/1ps

module aocg_top_properties
   import aocg_pkg::*;
(
   input  wire logic            i_clk_sys,
   input  wire logic            i_resetn,
   input  wire logic            i_clk_en,
   input  wire logic            i_psel,
   input  wire logic            i_penable,
   input  wire logic            i_pwrite,
   input  wire logic [7:0]      i_paddr,
   input  wire logic            i_smp_valid,
   input  wire aocg_scale_type  i_fact_x_scale,
   input  wire logic [31:0]     o_prdata,
   input  wire logic            o_pready,
   input  wire logic            o_pslverr,
   input  wire logic            o_ext_valid,
   input  wire aocg_sample_type o_ext_x,
   input  wire aocg_scale_type  o_x_axis_scale
);
   // ====
   // Bus answer
   default clocking cb_sys @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);

   property p_ready_next;
      i_psel && !i_penable && i_clk_en |=> o_pready;
   endproperty
   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
   property p_ready_one;
      o_pready |=> !o_pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready held too long");
   property p_err_addr;
      i_psel && !i_penable && i_clk_en && i_paddr[1:0] != 2'h0 |=> o_pready && o_pslverr;
   endproperty
   a_err_addr: assert property (p_err_addr) else $error("unaligned not refused");
   property p_wr_zero;
      o_pready && i_pwrite |-> o_prdata == 32'h00000000;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("data on write");
   property p_rd_upper;
      o_pready |-> o_prdata[31:8] == 24'h000000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   // ====
   // Sample path, one cycle; outputs hold between samples
   property p_ext_pulse;
      i_smp_valid && i_clk_en |=> o_ext_valid;
   endproperty
   a_ext_pulse: assert property (p_ext_pulse) else $error("sample not answered");
   property p_ext_quiet;
      !i_smp_valid && i_clk_en |=> !o_ext_valid;
   endproperty
   a_ext_quiet: assert property (p_ext_quiet) else $error("spurious result");
   property p_ext_hold;
      !o_ext_valid |-> $stable(o_ext_x);
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("result moved idle");
   // Factory scale shows two edges after release; no write can land earlier
   property p_scale_boot;
      $rose(i_resetn) |-> ##2 o_x_axis_scale == i_fact_x_scale;
   endproperty
   a_scale_boot: assert property (p_scale_boot) else $error("factory scale missing");
   // Clock enable low freezes every result and copy
   property p_frozen;
      !i_clk_en |=> $stable(o_ext_valid) && $stable(o_ext_x) && $stable(o_x_axis_scale);
   endproperty
   a_frozen: assert property (p_frozen) else $error("state moved while frozen");
endmodule : aocg_top_properties

bind aocg_top aocg_top_properties u_props (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_smp_valid(i_smp_valid),
   .i_fact_x_scale(i_fact_x_scale), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_ext_valid(o_ext_valid), .o_ext_x(o_ext_x),
   .o_x_axis_scale(o_x_axis_scale)
);

/* File: sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top
   import aocg_pkg::*;
;
   // ====
   // Stimulus and observation
   logic            clk = 1'b0;
   logic            resetn = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h00000000;
   logic [31:0]     prdata, rdata;
   logic            pready, pslverr, err, ext_valid;
   logic            smp_valid = 1'b0;
   logic            clk_en = 1'h1;
   logic [7:0]      b;
   aocg_sample_type smp [3] = '{default: 16'h0000};
   aocg_sample_type ext [3];
   aocg_scale_type  sco [3];
   aocg_bias_type   cb [3];
   aocg_bias_type   fact_b [3] = '{15'h1234, 15'h7F01, 15'h0ABC};
   aocg_scale_type  fact_s [3] = '{9'h155, 9'h0AA, 9'h1C3};
   int              num_errors = 0;
   int              checked = 0;

   always #20 clk = ~clk;

   aocg_top dut (
      .i_clk_sys(clk), .i_resetn(resetn), .i_clk_en(clk_en), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_smp_valid(smp_valid), .i_smp_x(smp[0]), .i_smp_y(smp[1]), .i_smp_z(smp[2]),
      .i_fact_x_bias(fact_b[0]), .i_fact_y_bias(fact_b[1]), .i_fact_z_bias(fact_b[2]),
      .i_fact_x_scale(fact_s[0]), .i_fact_y_scale(fact_s[1]), .i_fact_z_scale(fact_s[2]),
      .o_ext_valid(ext_valid), .o_ext_x(ext[0]), .o_ext_y(ext[1]), .o_ext_z(ext[2]),
      .o_x_axis_scale(sco[0]), .o_y_axis_scale(sco[1]), .o_z_axis_scale(sco[2])
   );

   // ====
   // Tasks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   // Request held until pready seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(nm, e, rdata);
      chk({nm, " err"}, 32'h00000000, {31'h0, err});
   endtask : rd

   function automatic logic [15:0] sat(input logic [15:0] s, input logic [14:0] bb);
      logic [16:0] t;
      t = {s[15], s} + {{2{bb[14]}}, bb};
      if (t[16] != t[15]) return t[16] ? 16'h8000 : 16'h7FFF;
      return t[15:0];
   endfunction : sat

   task automatic smp_chk(input logic [15:0] v);
      @(posedge clk);
      smp_valid <= 1'b1;
      foreach (smp[i]) smp[i] <= v;
      @(posedge clk);
      smp_valid <= 1'b0;
      #1;
      chk("ext_valid", 32'h00000001, {31'h0, ext_valid});
      foreach (ext[i]) chk("ext", {16'h0, sat(v, cb[i])}, {16'h0, ext[i]});
   endtask : smp_chk

   // Scale output lags its register; the reads give it time
   task automatic cal_chk(input int a, input logic [14:0] bb, input logic [8:0] ss);
      rd("bias_lo", 8'hA8 + 8'(a * 8), {24'h0, bb[7:0]});
      rd("bias_hi", 8'hAC + 8'(a * 8), {24'h0, ss[8], bb[14:8]});
      rd("scale_lo", 8'hC0 + 8'(a * 4), {24'h0, ss[7:0]});
      chk("scale_out", {23'h0, ss}, {23'h0, sco[a]});
   endtask : cal_chk

   // ====
   // Tests
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      for (int a = 0; a < 3; a++) cal_chk(a, fact_b[a], fact_s[a]);
      rd("status", 8'hD0, 32'h00000000);
      cb = fact_b;
      smp_chk(16'h0100);
      smp_chk(16'h7FF0);
      smp_chk(16'h8005);
      $display("test factory_load done");
      for (int a = 0; a < 3; a++) begin
         cb[a] = 15'h2A5A ^ 15'(a);
         apb(1'b1, 8'hA8 + 8'(a * 8), {24'h0, cb[a][7:0]});
         apb(1'b0, 8'hAC + 8'(a * 8), 32'h00000000);
         b = rdata[7:0];
         apb(1'b1, 8'hAC + 8'(a * 8), {24'h0, ~b[7], cb[a][14:8]});
         apb(1'b1, 8'hC0 + 8'(a * 4), {24'h0, ~fact_s[a][7:0]});
         cal_chk(a, cb[a], ~fact_s[a]);
      end
      rd("status", 8'hD0, 32'h00000002);
      smp_chk(16'h0010);
      $display("test overwrite done");
      apb(1'b0, 8'h00, 32'h00000000);
      chk("unmapped err", 32'h00000001, {31'h0, err});
      chk("unmapped data", 32'h00000000, rdata);
      apb(1'b1, 8'hA9, 32'h00000077);
      chk("unaligned err", 32'h00000001, {31'h0, err});
      rd("bias_lo kept", 8'hA8, {24'h0, cb[0][7:0]});
      $display("test refused done");
      // Bias off, then reload of factory values
      apb(1'b1, 8'hCC, 32'h00000000);
      cb = '{default: 15'h0000};
      smp_chk(16'h1234);
      apb(1'b1, 8'hCC, 32'h00000003);
      repeat (2) @(posedge clk);
      cb = fact_b;
      for (int a = 0; a < 3; a++) cal_chk(a, fact_b[a], fact_s[a]);
      rd("status", 8'hD0, 32'h00000000);
      smp_chk(16'hFF00);
      $display("test reload done");
      // Clock enable low: an offered sample must not be taken
      @(posedge clk);
      clk_en <= 1'h0;
      smp_valid <= 1'h1;
      foreach (smp[i]) smp[i] <= 16'h0055;
      repeat (2) @(posedge clk);
      #1;
      chk("frozen valid", 32'h00000000, {31'h0, ext_valid});
      @(posedge clk);
      smp_valid <= 1'h0;
      clk_en <= 1'h1;
      @(posedge clk);
      #1;
      foreach (ext[i]) chk("frozen ext", {16'h0, sat(16'hFF00, cb[i])}, {16'h0, ext[i]});
      $display("test freeze done");
      tally_and_finish();
   end
endmodule : tb_top
